// ### logic/gpd_port.sv
`timescale 1ns/1ps
module gpd_port #(
  parameter bit LOW_POWER = 1'b1
) (
  input wire logic sysClk,
  input wire logic rstn,
  // software side
  input wire logic [7:0] dataWrite,
  input wire logic dataWriteStrobe,
  output logic [7:0] dataOut,
  output logic [7:0] pinLevel,
  input wire logic [7:0] dirWrite,
  input wire logic dirWriteStrobe,
  output logic [7:0] dirOut,
  input wire logic [7:0] debounceEnable,
  input wire logic [7:0] irqEnable,
  input wire logic [7:0] irqLevelMode,
  input wire logic [7:0] irqPolarityHigh,
  input wire logic [7:0] irqClearMask,
  input wire logic irqClearStrobe,
  output logic [7:0] irqPending,
  output logic [7:0] pinIrq,
  output logic combinedIrq,
  output logic wakeRequest,
  // peripheral ownership
  input wire logic [7:0] altFunctionSelect,
  // pins
  input wire logic [7:0] padIn,
  output logic [7:0] padOut,
  output logic [7:0] padOutEnable
);
  logic [7:0] padMeta;
  logic [7:0] padSync;
  logic [7:0] debounced;
  logic [7:0] filtered;
  logic [7:0] filteredPrev;
  logic [7:0] irqEvent;
  logic [8:0] slowDiv;
  logic slowTick;
  logic [7:0] clearBits;

  // ***********************************
  // shared decode
  // ***********************************
  // bits of a pin vector that the port still owns
  function automatic logic [7:0] ownedBits(input logic [7:0] bits, input logic [7:0] alt);
    return bits & ~alt;
  endfunction

  // one match per pin: level against polarity, or a single edge in the polarity's direction
  function automatic logic [7:0] eventMatch(
    input logic [7:0] now,
    input logic [7:0] prev,
    input logic [7:0] levelMode,
    input logic [7:0] polarityHigh
  );
    logic [7:0] levelHit;
    logic [7:0] riseHit;
    logic [7:0] fallHit;
    levelHit = levelMode & ~(now ^ polarityHigh);
    riseHit = ~levelMode & polarityHigh & now & ~prev;
    fallHit = ~levelMode & ~polarityHigh & ~now & prev;
    return levelHit | riseHit | fallHit;
  endfunction

  // ***********************************
  // pin synchroniser
  // ***********************************
  // two flops before any logic reads a pad; only padSync is read downstream
  always_ff @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      padMeta <= gpd_pkg::ZERO8;
      padSync <= gpd_pkg::ZERO8;
    end else begin
      padMeta <= padIn;
      padSync <= padMeta;
    end
  end

  // ***********************************
  // 32 kHz enable divider
  // ***********************************
  // one clock only: the slow rate is an enable pulse, so no crossing is needed
  // the divide rounds down, so a tick period never exceeds the slow clock period
  always_ff @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      slowDiv <= gpd_pkg::SLOW_DIV_ZERO;
    end else if (slowDiv == gpd_pkg::SLOW_DIV_LAST) begin
      slowDiv <= gpd_pkg::SLOW_DIV_ZERO;
    end else begin
      slowDiv <= slowDiv + 9'h001;
    end
  end
  assign slowTick = (slowDiv == gpd_pkg::SLOW_DIV_LAST);

  // ***********************************
  // debouncers
  // ***********************************
  for (genvar i = 0; i < gpd_pkg::PIN_COUNT; i++) begin : g_deb
    gpd_debounce u_deb (
      .sysClk(sysClk),
      .rstn(rstn),
      .slowTick(slowTick),
      .rawLevel(padSync[i]),
      .stableLevel(debounced[i])
    );
  end

  // bypass per pin; debounced path already in this domain
  always_comb begin
    filtered = (debounceEnable & debounced) | (~debounceEnable & padSync);
  end

  // ***********************************
  // data and direction registers
  // ***********************************
  always_ff @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      dataOut <= gpd_pkg::DATA_RESET;
    end else if (dataWriteStrobe) begin
      dataOut <= dataWrite;
    end
  end

  always_ff @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      dirOut <= gpd_pkg::DIR_RESET;
    end else if (dirWriteStrobe) begin
      dirOut <= dirWrite;
    end
  end

  // readback shows the synchronised pad level for all eight pins
  always_ff @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      pinLevel <= gpd_pkg::ZERO8;
    end else begin
      pinLevel <= padSync;
    end
  end

  // ***********************************
  // pad drive
  // ***********************************
  // an alternate function owns the pad, so the port lets go of it entirely
  always_ff @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      padOut <= gpd_pkg::ZERO8;
    end else begin
      padOut <= ownedBits(dataOut, altFunctionSelect);
    end
  end

  // the enable is masked on the same edge as the data, so a released pad never glitches
  always_ff @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      padOutEnable <= gpd_pkg::ZERO8;
    end else begin
      padOutEnable <= ownedBits(dirOut, altFunctionSelect);
    end
  end

  // ***********************************
  // interrupts
  // ***********************************
  always_ff @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      filteredPrev <= gpd_pkg::ZERO8;
    end else begin
      filteredPrev <= filtered;
    end
  end

  // level mode: matching level; edge mode: rising or falling per polarity
  always_comb begin
    irqEvent = ownedBits(irqEnable, altFunctionSelect) &
      eventMatch(filtered, filteredPrev, irqLevelMode, irqPolarityHigh);
  end

  // the mask only counts in the strobe cycle, so a stale mask clears nothing
  always_comb begin
    clearBits = irqClearStrobe ? irqClearMask : gpd_pkg::ZERO8;
  end

  // a new event in the clear cycle wins over the clear
  always_ff @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      irqPending <= gpd_pkg::ZERO8;
    end else begin
      irqPending <= (irqPending & ~clearBits) | irqEvent;
    end
  end

  // ***********************************
  // interrupt outputs
  // ***********************************
  // each pin has its own request line
  assign pinIrq = irqPending;

  // ***********************************
  // combined request and wake-up
  // ***********************************
  // combined output is held low unless LOW_POWER is set
  always_ff @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      combinedIrq <= 1'b0;
    end else begin
      combinedIrq <= LOW_POWER & (|irqPending);
    end
  end

  assign wakeRequest = combinedIrq;
endmodule

// ### shared/gpd_pkg.sv
package gpd_pkg;
  // ***********************************
  // port geometry
  // ***********************************
  localparam int PIN_COUNT = 8;
  // ***********************************
  // reset values
  // ***********************************
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] ZERO8 = 8'h00;
  // ***********************************
  // timing
  // ***********************************
  localparam int SYS_CLK_HZ = 10000000;
  localparam int SLOW_CLK_HZ = 32768;
  // slow tick divider, rounded down so one tick is never longer than a 32 kHz period
  localparam int SLOW_DIV = SYS_CLK_HZ / SLOW_CLK_HZ;
  localparam logic [8:0] SLOW_DIV_LAST = 9'(SLOW_DIV - 1);
  localparam logic [8:0] SLOW_DIV_ZERO = 9'h000;
  // further samples that must agree with the first before a new level passes
  localparam int STABLE_TICKS = 2;
  localparam logic [1:0] STABLE_LAST = 2'(STABLE_TICKS);
  localparam logic [1:0] STABLE_ZERO = 2'h0;
  localparam logic [1:0] STABLE_ONE = 2'h1;
endpackage

// ### logic/gpd_debounce.sv
`timescale 1ns/1ps
// ***********************************
// one-pin debouncer on the 32 kHz enable
// ***********************************
module gpd_debounce (
  input wire logic sysClk,
  input wire logic rstn,
  input wire logic slowTick,
  input wire logic rawLevel,
  output logic stableLevel
);
  logic candidate;
  logic [1:0] agreeCount;

  // a level passes only after it has held for two whole slow periods
  always_ff @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      candidate <= 1'b0;
      agreeCount <= gpd_pkg::STABLE_ZERO;
      stableLevel <= 1'b0;
    end else if (slowTick) begin
      if (rawLevel != candidate) begin
        candidate <= rawLevel;
        agreeCount <= gpd_pkg::STABLE_ONE;
      end else if (agreeCount != gpd_pkg::STABLE_LAST) begin
        agreeCount <= agreeCount + gpd_pkg::STABLE_ONE;
      end else begin
        stableLevel <= candidate;
      end
    end
  end
endmodule

// ### verif/gpd_port_asserts.sv
`timescale 1ns/1ps
// ***
// port checker
// ***
module gpd_port_asserts #(
  parameter bit LOW_POWER = 1'b1
) (
  input wire logic sysClk,
  input wire logic rstn,
  input wire logic [7:0] dataWrite,
  input wire logic dataWriteStrobe,
  input wire logic [7:0] dataOut,
  input wire logic [7:0] pinLevel,
  input wire logic [7:0] dirOut,
  input wire logic [7:0] irqEnable,
  input wire logic [7:0] irqClearMask,
  input wire logic irqClearStrobe,
  input wire logic [7:0] irqPending,
  input wire logic [7:0] pinIrq,
  input wire logic combinedIrq,
  input wire logic wakeRequest,
  input wire logic [7:0] altFunctionSelect,
  input wire logic [7:0] padIn,
  input wire logic [7:0] padOut,
  input wire logic [7:0] padOutEnable
);
  default clocking @(posedge sysClk); endclocking
  default disable iff (!rstn);
  // the pad must sit still through the whole sync pipeline
  sequence padQuiet;
    $stable(padIn)[*4];
  endsequence
  data_write_a: assert property (dataWriteStrobe |=> dataOut == $past(dataWrite))
    else $error("data reg");
  pad_drive_a: assert property (1 |=> padOut == $past(dataOut & ~altFunctionSelect))
    else $error("pad out");
  pad_enable_a: assert property (1 |=> padOutEnable == $past(dirOut & ~altFunctionSelect))
    else $error("pad enable");
  pin_read_a: assert property (padQuiet |=> pinLevel == $past(padIn))
    else $error("pin level");
  pin_irq_a: assert property ((pinIrq == irqPending) &&
    ((pinIrq & ~$past(pinIrq) & ~$past(irqEnable & ~altFunctionSelect)) == 8'h00)) else $error("pin irq");
  combined_irq_a: assert property (1 |=> combinedIrq == (LOW_POWER && |$past(irqPending)))
    else $error("combined irq");
  wake_req_a: assert property ((wakeRequest == combinedIrq) && (!wakeRequest || $past(|pinIrq)))
    else $error("wake");
  pend_hold_a: assert property ((~irqPending & $past(irqPending) &
    ~($past(irqClearMask) & {8{$past(irqClearStrobe)}})) == 8'h00) else $error("pending lost");
endmodule
bind gpd_port gpd_port_asserts #(.LOW_POWER(LOW_POWER)) chk (
  .sysClk(sysClk),
  .rstn(rstn),
  .dataWrite(dataWrite),
  .dataWriteStrobe(dataWriteStrobe),
  .dataOut(dataOut),
  .pinLevel(pinLevel),
  .dirOut(dirOut),
  .irqEnable(irqEnable),
  .irqClearMask(irqClearMask),
  .irqClearStrobe(irqClearStrobe),
  .irqPending(irqPending),
  .pinIrq(pinIrq),
  .combinedIrq(combinedIrq),
  .wakeRequest(wakeRequest),
  .altFunctionSelect(altFunctionSelect),
  .padIn(padIn),
  .padOut(padOut),
  .padOutEnable(padOutEnable)
);

// ### verif/gpd_pins.sv
`timescale 1ns/1ps
// ***
// switches and leds on the pads
// ***
module gpd_pins (
  input wire logic [7:0] padOut,
  input wire logic [7:0] padOutEnable,
  input wire logic [7:0] sw,
  output logic [7:0] padIn
);
  // a driven pad wins; switches only reach released pads
  assign padIn = (padOut & padOutEnable) | (sw & ~padOutEnable);
endmodule

// ### verif/gpd_port_tb.sv
`timescale 1ns/1ps
module gpd_port_tb;
  logic sysClk = 1'h0;
  logic rstn = 1'h0;
  logic [7:0] dataWrite = 8'h00, dirWrite = 8'h00, debounceEnable = 8'h00, irqEnable = 8'h00;
  logic [7:0] irqLevelMode = 8'h00, sw = 8'h00;
  logic [7:0] irqPolarityHigh = 8'h00, irqClearMask = 8'h00, altFunctionSelect = 8'h00;
  logic dataWriteStrobe = 1'h0, dirWriteStrobe = 1'h0, irqClearStrobe = 1'h0;
  wire [7:0] dataOut, pinLevel, dirOut, irqPending, pinIrq, padIn, padOut, padOutEnable;
  wire combinedIrq, wakeRequest;
  int miscompares = 0, total_checks = 0, ticks = 0;
  always #50 sysClk = ~sysClk;
  gpd_port DUT (
    .sysClk(sysClk),
    .rstn(rstn),
    .dataWrite(dataWrite),
    .dataWriteStrobe(dataWriteStrobe),
    .dataOut(dataOut),
    .pinLevel(pinLevel),
    .dirWrite(dirWrite),
    .dirWriteStrobe(dirWriteStrobe),
    .dirOut(dirOut),
    .debounceEnable(debounceEnable),
    .irqEnable(irqEnable),
    .irqLevelMode(irqLevelMode),
    .irqPolarityHigh(irqPolarityHigh),
    .irqClearMask(irqClearMask),
    .irqClearStrobe(irqClearStrobe),
    .irqPending(irqPending),
    .pinIrq(pinIrq),
    .combinedIrq(combinedIrq),
    .wakeRequest(wakeRequest),
    .altFunctionSelect(altFunctionSelect),
    .padIn(padIn),
    .padOut(padOut),
    .padOutEnable(padOutEnable)
  );
  gpd_pins pins (
    .padOut(padOut),
    .padOutEnable(padOutEnable),
    .sw(sw),
    .padIn(padIn)
  );
  task automatic cyc(int n);
    repeat (n) @(negedge sysClk);
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(logic [7:0] d, logic [7:0] r);
    dataWrite = d;
    dirWrite = r;
    {dataWriteStrobe, dirWriteStrobe} = 2'h3;
    cyc(1);
    {dataWriteStrobe, dirWriteStrobe} = 2'h0;
    cyc(1);
  endtask
  task automatic clr(logic [7:0] m);
    irqClearMask = m;
    irqClearStrobe = 1'h1;
    cyc(1);
    irqClearStrobe = 1'h0;
    cyc(1);
  endtask
  task automatic t_drive;
    altFunctionSelect = 8'h02;
    sw = 8'h3c;
    wr(8'ha5, 8'h0f);
    wr(8'h5a, 8'h0f);
    cyc(5);
    chk(dataOut, 8'h5a);
    chk(dirOut, 8'h0f);
    chk(padOut, 8'h58);
    chk(padOutEnable, 8'h0d);
    chk(pinLevel, 8'h38);
  endtask
  task automatic t_irq;
    irqPolarityHigh = 8'hff;
    irqEnable = 8'hc0;
    cyc(5);
    sw = 8'h7c;
    cyc(6);
    chk(pinIrq, 8'h40);
    chk({7'h00, wakeRequest}, 8'h01);
    clr(8'h40);
    irqLevelMode = 8'h80;
    irqPolarityHigh = 8'h7f;
    cyc(4);
    chk({combinedIrq, irqPending[6:0]}, 8'h80);
    clr(8'h80);
    cyc(4);
    chk(irqPending, 8'h80);
  endtask
  task automatic t_deb;
    sw = 8'h5c;
    debounceEnable = 8'h20;
    irqEnable = 8'h20;
    irqLevelMode = 8'h00;
    irqPolarityHigh = 8'hff;
    cyc(1000);
    clr(8'hff);
    sw = 8'h7c;
    cyc(100);
    sw = 8'h5c;
    cyc(900);
    chk(irqPending, 8'h00);
    sw = 8'h7c;
    cyc(500);
    chk(irqPending, 8'h00);
    cyc(600);
    chk(irqPending, 8'h20);
  endtask
  task automatic t_modes;
    debounceEnable = 8'h00;
    irqEnable = 8'h50;
    irqLevelMode = 8'h40;
    irqPolarityHigh = 8'h40;
    cyc(2);
    clr(8'hff);
    chk(irqPending, 8'h40);
    sw = 8'h6c;
    cyc(5);
    chk(irqPending, 8'h50);
  endtask
  always @(posedge sysClk) begin
    ticks++;
    if (ticks == 6000) begin
      miscompares++;
      test_done;
    end
  end
  initial begin
    cyc(2);
    rstn = 1'h1;
    t_drive;
    t_irq;
    t_deb;
    t_modes;
    test_done;
  end
endmodule
